//--- hw/ses_pkg.sv
// Shared constants and carrier types for the serial EEPROM bus slave front end.
// Assumes a 200 MHz system clock; the serial clock comes from an external master.
package ses_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS  = 5;    // System clock period
  localparam int HOLD_NS     = 200;  // Output hold past falling serial clock
  localparam int HOLD_CYC    = (HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;  // Least time, rounded up
  localparam int STALL_MS    = 30;   // clock_stall_limit, inside 25..35 ms
  localparam int STALL_CYC   = STALL_MS * 1000000 / SYS_CLK_NS;          // Longest time, rounded down
  localparam int BUS_CLOCK_RATE_MIN_KHZ = 10;  // bus_clock_rate floor that keeps the watchdog quiet

  // ----------------------------------------------------------------
  // Control byte and memory geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_MEM  = 4'hA;  // Normal memory access class
  localparam logic [3:0] CODE_PROT = 4'h6;  // Protect and bank command class
  localparam int WR_KEEP    = 16;           // Write bytes retained per frame
  localparam int MEM_BITS   = 4096;         // Array size behind the interface
  localparam int MEM_BANKS  = 2;
  localparam int PROT_BLKS  = 4;
  localparam int BANK_BITS  = MEM_BITS / MEM_BANKS;
  localparam int BLOCK_BITS = MEM_BITS / PROT_BLKS;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_HALT = 1'b1;  // Interface ignores traffic until a start

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLS_NONE = 2'h0,
    CLS_MEM  = 2'h1,
    CLS_PROT = 2'h2
  } ses_cls_t;

  typedef enum logic [3:0] {
    LS_IDLE = 4'h1,
    LS_CTRL = 4'h2,
    LS_RXD  = 4'h4,
    LS_TXD  = 4'h8
  } ses_lstate_t;

  // Decoded control byte as seen by the rest of the device
  typedef struct packed {
    ses_cls_t   cls;      // Command class
    logic [2:0] cs;       // Chip-select bits of the control byte
    logic       rd;       // Direction, one for read
    logic       match;    // Device addressed
    logic       prot_en;  // Set/clear protect allowed
  } ses_cmd_t;

endpackage

//--- hw/ses_bus_slave.sv
// Two-wire serial slave front end: start/stop, framing, acknowledge, watchdog, control decode.
// Assumes scl is the master's clock pin, used as a clock; sda is open drain with a pull-up.
//
// Contract
// (R1) Start is data falling with clock high
// (R2) Stop is data rising with clock high
// (R3) Data change during clock high never data
// (R4) Master starts only on idle bus
// (R5) One bit per clock pulse, sampled clock high
// (R6) Keep last sixteen write bytes, oldest overwritten
// (R7) Acknowledge each received byte on ninth clock
// (R8) No acknowledge while programming is busy
// (R9) Acknowledge holds data low through clock high
// (R10) Master not-acknowledge on read: release data line
// (R11) Clock stall resets interface until next start
// (R12) Master keeps clock above minimum rate
// (R13) Hold output past falling clock edge
// (R14) Control byte upper nibble selects command class
// (R15) Chip-select bits must equal strap pins
// (R16) Control byte bit zero gives direction
// (R17) Protect class skips chip-select comparison
// (R18) Protect commands need high-voltage qualifier
// (R19) Data line only pulled low or released
// (R20) Device is purely a bus slave
// (R21) Array two banks, four protect blocks
// (R22) Stall threshold parameter, 25 to 35 ms
module ses_bus_slave #(
  parameter int STALL_CYCLES = ses_pkg::STALL_CYC,  // Clock-low watchdog length [R22]
  parameter int BUF_DEPTH    = ses_pkg::WR_KEEP     // Retained write bytes
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         scl,               // Serial clock from master
  input  wire logic                         sda_i,             // Serial data line level
  output logic                              sda_o,             // Always low when enabled
  output logic                              sda_oe,            // High pulls the line low
  input  wire logic                         chip_sel_bit0,
  input  wire logic                         chip_sel_bit1,
  input  wire logic                         chip_sel_bit2,
  input  wire logic                         strap_sel0_hv_pin, // High-voltage sensed on strap 0
  input  wire logic                         prog_busy,         // Programming cycle running
  input  wire logic [7:0]                   rd_byte,           // Next byte to send
  output logic                              rd_next,           // Pulse: present next rd_byte
  output ses_pkg::ses_cmd_t                 cmd,               // Last decoded control byte
  output logic                              cmd_valid,         // Pulse: cmd updated
  output logic [7:0]                        wr_data,           // Last received write byte
  output logic                              wr_valid,          // Pulse: wr_data updated
  input  wire logic [$clog2(BUF_DEPTH)-1:0] buf_idx,           // Retained byte read index
  output logic [7:0]                        buf_data,          // Retained byte at buf_idx
  output logic [$clog2(BUF_DEPTH)-1:0]      buf_head,          // Oldest slot when full
  output logic [$clog2(BUF_DEPTH):0]        wr_count,          // Bytes retained
  output logic                              frame_active,      // Between start and stop or clock stall
  output logic                              stop_seen,         // Pulse: stop detected
  output logic                              bus_timeout        // Stall seen, until next start
);

  // ----------------------------------------------------------------
  // Local widths and constants
  // ----------------------------------------------------------------
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int TW = $clog2(STALL_CYCLES + 1);
  localparam int HW = $clog2(ses_pkg::HOLD_CYC + 1);
  localparam logic [TW-1:0] TO_LAST  = TW'(STALL_CYCLES - 1);
  localparam logic [HW-1:0] HOLD_LIM = HW'(ses_pkg::HOLD_CYC);
  localparam logic [AW:0]   KEEP_MAX = (AW+1)'(BUF_DEPTH);
  // Bank and block sizes only shape the decode downstream [R21]
  localparam int BANK_BYTES = ses_pkg::BANK_BITS / 8;
  localparam int BLK_BYTES  = ses_pkg::BLOCK_BITS / 8;

  // ----------------------------------------------------------------
  // System-domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                         scl_s1, scl_s2, scl_s3;  // Clock pin sync and history
    logic                         sda_s1, sda_s2, sda_s3;  // Data pin sync and history
    logic                         hv_s1, hv_s2;            // Strap 0 high-voltage sync
    logic                         drv_s1, drv_s2;          // Link drive request sync
    logic                         cmd_s1, cmd_s2, cmd_s3;  // Control byte toggle sync
    logic                         byt_s1, byt_s2, byt_s3;  // Write byte toggle sync
    logic                         rdt_s1, rdt_s2, rdt_s3;  // Read consume toggle sync
    logic                         halt;                    // Ignore bus until start
    logic                         start_t;                 // Toggles once per start
    logic [TW-1:0]                to_cnt;                  // Clock-low run length
    logic                         timed_out;
    logic [HW-1:0]                hold_cnt;                // Cycles since clock fell
    logic                         oe;
    logic                         sda_o;
    ses_pkg::ses_cmd_t            cmd;
    logic                         cmd_valid;
    logic                         wr_valid;
    logic [7:0]                   wr_data;
    logic [AW-1:0]                wp;                      // Next slot, oldest when full
    logic [AW:0]                  count;
    logic [BUF_DEPTH-1:0][7:0]    mem;                     // Retained write bytes
    logic [7:0]                   buf_data;
    logic                         rd_next;
    logic                         rd_load;
    logic [7:0]                   rd_hold;                 // Byte offered to the link
    logic                         stop_pulse;
    logic                         active;
  } ses_sys_t;

  // ----------------------------------------------------------------
  // Link-domain state (serial clock)
  // ----------------------------------------------------------------
  typedef struct packed {
    ses_pkg::ses_lstate_t st;
    logic [3:0]           cnt;         // Bits handled in current byte
    logic [7:0]           sh;          // Receive or transmit shifter
    logic                 drive;       // Request to pull the line low
    logic                 last_bit;    // Data at previous rising edge
    logic                 cmd_tog;
    logic                 byte_tog;
    logic                 rd_tog;
    logic [7:0]           ctl;         // Held control byte
    logic                 match;       // Held addressing verdict
    logic [7:0]           rxb;         // Held write byte
    logic                 start_seen;
    logic                 start_s2, halt_s2, busy_s2;
    logic [2:0]           strap_s2;
  } ses_lnk_t;

  // First sync stage on the falling serial edge
  typedef struct packed {
    logic       start_s1, halt_s1, busy_s1;
    logic [2:0] strap_s1;
  } ses_lnf_t;

  ses_sys_t s_r, s_nxt;
  ses_lnk_t k_r, k_nxt;
  ses_lnf_t f_r;
  logic     start_det;
  logic     stop_det;

  // ----------------------------------------------------------------
  // Bus condition detection on synchronised pins
  // ----------------------------------------------------------------
  // Only edges of data while clock is high count as events [R3]
  assign start_det = s_r.scl_s2 & s_r.scl_s3 & s_r.sda_s3 & ~s_r.sda_s2;  // [R1]
  assign stop_det  = s_r.scl_s2 & s_r.scl_s3 & ~s_r.sda_s3 & s_r.sda_s2;  // [R2]

  // ----------------------------------------------------------------
  // System-domain next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Pin and crossing synchronisers
    s_nxt.scl_s1 = scl;
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_s3 = s_r.scl_s2;
    s_nxt.sda_s1 = sda_i;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_s3 = s_r.sda_s2;
    s_nxt.hv_s1  = strap_sel0_hv_pin;
    s_nxt.hv_s2  = s_r.hv_s1;
    s_nxt.drv_s1 = k_r.drive;
    s_nxt.drv_s2 = s_r.drv_s1;
    s_nxt.cmd_s1 = k_r.cmd_tog;
    s_nxt.cmd_s2 = s_r.cmd_s1;
    s_nxt.cmd_s3 = s_r.cmd_s2;
    s_nxt.byt_s1 = k_r.byte_tog;
    s_nxt.byt_s2 = s_r.byt_s1;
    s_nxt.byt_s3 = s_r.byt_s2;
    s_nxt.rdt_s1 = k_r.rd_tog;
    s_nxt.rdt_s2 = s_r.rdt_s1;
    s_nxt.rdt_s3 = s_r.rdt_s2;
    // Pulses last one cycle
    s_nxt.cmd_valid  = 1'b0;
    s_nxt.wr_valid   = 1'b0;
    s_nxt.rd_next    = 1'b0;
    s_nxt.stop_pulse = 1'b0;
    s_nxt.sda_o      = 1'b0;  // Never drive high, only pull low [R19]
    // Watchdog on a stalled clock line
    if (s_r.scl_s2) begin
      s_nxt.to_cnt = '0;
    end else if (s_r.to_cnt == TO_LAST) begin
      s_nxt.halt      = 1'b1;  // [R11]
      s_nxt.timed_out = 1'b1;
      s_nxt.active    = 1'b0;
    end else begin
      s_nxt.to_cnt = s_r.to_cnt + 1'b1;  // [R22]
    end
    // Stop ends the frame
    if (stop_det) begin
      s_nxt.halt       = 1'b1;
      s_nxt.active     = 1'b0;
      s_nxt.stop_pulse = 1'b1;
    end
    // Start opens a fresh frame and lifts any halt
    if (start_det) begin
      s_nxt.halt      = 1'b0;  // [R11]
      s_nxt.timed_out = 1'b0;
      s_nxt.start_t   = ~s_r.start_t;
      s_nxt.active    = 1'b1;
      s_nxt.wp        = '0;
      s_nxt.count     = '0;
      s_nxt.rd_next   = 1'b1;  // Prefetch first read byte
      s_nxt.rd_load   = 1'b1;
    end
    // Hold counter: drive changes wait 200 ns after the clock falls
    if (s_r.scl_s2) begin
      s_nxt.hold_cnt = '0;
    end else if (s_r.hold_cnt != HOLD_LIM) begin
      s_nxt.hold_cnt = s_r.hold_cnt + 1'b1;
    end
    if (s_r.halt) begin
      s_nxt.oe = 1'b0;
    end else if (!s_r.scl_s2 && s_r.hold_cnt == HOLD_LIM) begin
      s_nxt.oe = s_r.drv_s2;  // [R13] [R9]
    end
    // Control byte arrives from the link; words are stable by the toggle
    if (s_r.cmd_s3 != s_r.cmd_s2) begin
      s_nxt.cmd_valid = 1'b1;
      s_nxt.cmd.cs    = k_r.ctl[3:1];
      s_nxt.cmd.rd    = k_r.ctl[0];
      s_nxt.cmd.match = k_r.match;
      if (k_r.ctl[7:4] == ses_pkg::CODE_MEM) begin
        s_nxt.cmd.cls = ses_pkg::CLS_MEM;
      end else if (k_r.ctl[7:4] == ses_pkg::CODE_PROT) begin
        s_nxt.cmd.cls = ses_pkg::CLS_PROT;
      end else begin
        s_nxt.cmd.cls = ses_pkg::CLS_NONE;
      end
      // Protect writes only with the high voltage present [R18]
      s_nxt.cmd.prot_en = (k_r.ctl[7:4] == ses_pkg::CODE_PROT) & ~k_r.ctl[0] & s_r.hv_s2;
    end
    // Write bytes fill a ring; oldest replaced once full [R6]
    if (s_r.byt_s3 != s_r.byt_s2) begin
      s_nxt.wr_valid     = 1'b1;
      s_nxt.wr_data      = k_r.rxb;
      s_nxt.mem[s_r.wp]  = k_r.rxb;
      s_nxt.wp           = AW'(s_r.wp + 1'b1);
      if (s_r.count != KEEP_MAX) begin
        s_nxt.count = s_r.count + 1'b1;
      end
    end
    s_nxt.buf_data = s_r.mem[buf_idx];
    // Link consumed the offered byte: ask for the next
    if (s_r.rdt_s3 != s_r.rdt_s2) begin
      s_nxt.rd_next = 1'b1;
      s_nxt.rd_load = 1'b1;
    end
    if (s_r.rd_load) begin
      s_nxt.rd_hold = rd_byte;
      s_nxt.rd_load = 1'b0;
    end
  end

  // System-domain register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r      <= '0;
      s_r.halt <= ses_pkg::RST_HALT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: first sync stage on the falling serial edge
  // ----------------------------------------------------------------
  // Start is caught here at the fall after it, ready for the next rise.
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      f_r         <= '0;
      f_r.halt_s1 <= ses_pkg::RST_HALT;
    end else begin
      f_r.start_s1 <= s_r.start_t;
      f_r.halt_s1  <= s_r.halt;
      f_r.busy_s1  <= prog_busy;
      f_r.strap_s1 <= {chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
    end
  end

  // ----------------------------------------------------------------
  // Link domain: framing on the rising serial edge
  // ----------------------------------------------------------------
  // The master owns the clock; the device only reacts to its edges [R20]
  always_comb begin
    logic [7:0] b;
    logic       addr_ok;
    b       = {k_r.sh[6:0], sda_i};
    addr_ok = 1'b0;
    k_nxt   = k_r;
    k_nxt.last_bit = sda_i;
    k_nxt.start_s2 = f_r.start_s1;
    k_nxt.halt_s2  = f_r.halt_s1;
    k_nxt.busy_s2  = f_r.busy_s1;
    k_nxt.strap_s2 = f_r.strap_s1;
    if (k_r.start_s2 != k_r.start_seen) begin
      // Start seen one rise late: first bit sits in last_bit
      k_nxt.start_seen = k_r.start_s2;
      k_nxt.st         = ses_pkg::LS_CTRL;
      k_nxt.sh         = {6'h00, k_r.last_bit, sda_i};  // [R5]
      k_nxt.cnt        = 4'h2;
      k_nxt.drive      = 1'b0;
    end else if (k_r.halt_s2) begin
      k_nxt.st    = ses_pkg::LS_IDLE;  // [R11]
      k_nxt.drive = 1'b0;
      k_nxt.cnt   = 4'h0;
    end else begin
      case (k_r.st)
        ses_pkg::LS_IDLE: begin
          k_nxt.drive = 1'b0;
        end
        ses_pkg::LS_CTRL, ses_pkg::LS_RXD: begin
          if (k_r.cnt < 4'h7) begin
            k_nxt.sh  = b;  // [R5]
            k_nxt.cnt = k_r.cnt + 4'h1;
          end else if (k_r.cnt == 4'h7) begin
            k_nxt.sh  = b;
            k_nxt.cnt = 4'h8;
            if (k_r.st == ses_pkg::LS_CTRL) begin
              // Class, chip select and direction [R14] [R15] [R16] [R17]
              addr_ok = ((b[7:4] == ses_pkg::CODE_MEM) && (b[3:1] == k_r.strap_s2)) ||
                        (b[7:4] == ses_pkg::CODE_PROT);
              k_nxt.ctl     = b;
              k_nxt.match   = addr_ok;
              k_nxt.cmd_tog = ~k_r.cmd_tog;
              k_nxt.drive   = addr_ok & ~k_r.busy_s2;  // [R7] [R8]
            end else begin
              k_nxt.drive = ~k_r.busy_s2;  // [R7] [R8]
              if (!k_r.busy_s2) begin
                k_nxt.rxb      = b;
                k_nxt.byte_tog = ~k_r.byte_tog;
              end
            end
          end else begin
            // Ninth clock: acknowledge slot ends here
            k_nxt.drive = 1'b0;
            k_nxt.cnt   = 4'h0;
            if (!k_r.drive) begin
              k_nxt.st = ses_pkg::LS_IDLE;
            end else if (k_r.st == ses_pkg::LS_CTRL && k_r.ctl[0]) begin
              k_nxt.st     = ses_pkg::LS_TXD;
              k_nxt.sh     = s_r.rd_hold;
              k_nxt.drive  = ~s_r.rd_hold[7];
              k_nxt.rd_tog = ~k_r.rd_tog;
            end else begin
              k_nxt.st = ses_pkg::LS_RXD;
            end
          end
        end
        ses_pkg::LS_TXD: begin
          if (k_r.cnt < 4'h7) begin
            k_nxt.drive = ~k_r.sh[3'(6 - k_r.cnt)];  // Low bit pulls, high bit releases [R19]
            k_nxt.cnt   = k_r.cnt + 4'h1;
          end else if (k_r.cnt == 4'h7) begin
            k_nxt.drive = 1'b0;  // Free the line for the master's answer
            k_nxt.cnt   = 4'h8;
          end else if (sda_i) begin
            k_nxt.st    = ses_pkg::LS_IDLE;  // Not acknowledged: stay released [R10]
            k_nxt.drive = 1'b0;
          end else begin
            k_nxt.sh     = s_r.rd_hold;
            k_nxt.drive  = ~s_r.rd_hold[7];
            k_nxt.rd_tog = ~k_r.rd_tog;
            k_nxt.cnt    = 4'h0;
          end
        end
        default: begin
          k_nxt.st    = ses_pkg::LS_IDLE;
          k_nxt.drive = 1'b0;
        end
      endcase
    end
  end

  // Link-domain register; the clock may stand still between frames
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      k_r         <= '0;
      k_r.st      <= ses_pkg::LS_IDLE;
      k_r.halt_s2 <= ses_pkg::RST_HALT;
    end else begin
      k_r <= k_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign sda_o        = s_r.sda_o;
  assign sda_oe       = s_r.oe;
  assign rd_next      = s_r.rd_next;
  assign cmd          = s_r.cmd;
  assign cmd_valid    = s_r.cmd_valid;
  assign wr_data      = s_r.wr_data;
  assign wr_valid     = s_r.wr_valid;
  assign buf_data     = s_r.buf_data;
  assign buf_head     = s_r.wp;
  assign wr_count     = s_r.count;
  assign frame_active = s_r.active;
  assign stop_seen    = s_r.stop_pulse;
  assign bus_timeout  = s_r.timed_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_line_low_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R19]
    s_r.sda_o == 1'b0) else $error("data output driven high");
  a_start_lifts: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    start_det |=> !s_r.halt && s_r.start_t != $past(s_r.start_t)) else $error("start not taken");
  a_stop_halts: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    stop_det |=> s_r.halt && s_r.stop_pulse && !s_r.active) else $error("stop not taken");
  a_oe_after_fall: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
    ($changed(s_r.oe) && !$past(s_r.halt)) |-> $past(s_r.hold_cnt) == HOLD_LIM && !$past(s_r.scl_s2))
    else $error("drive changed before hold time");
  a_stall_fires: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    (!s_r.scl_s2 && s_r.to_cnt == TO_LAST && !start_det) |=> s_r.halt && s_r.timed_out ##1 !s_r.oe)
    else $error("stall not handled");
  a_prot_needs_hv: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R18]
    (s_r.cmd_valid && s_r.cmd.prot_en) |-> $past(s_r.hv_s2) && s_r.cmd.cls == ses_pkg::CLS_PROT)
    else $error("protect enabled without high voltage");
  a_keep_sixteen: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    (s_r.byt_s3 != s_r.byt_s2 && s_r.count == KEEP_MAX && !start_det) |=> s_r.count == KEEP_MAX
    && s_r.wp == $past(s_r.wp) + 1'b1) else $error("ring overwrite wrong");
  a_busy_no_ack: assert property (@(posedge scl) disable iff (!rst_n) // [R8]
    (k_r.busy_s2 && k_r.cnt == 4'h7 && k_r.start_s2 == k_r.start_seen && !k_r.halt_s2
    && (k_r.st == ses_pkg::LS_CTRL || k_r.st == ses_pkg::LS_RXD)) |=> !k_r.drive)
    else $error("acknowledged while busy");
  a_nack_release: assert property (@(posedge scl) disable iff (!rst_n) // [R10]
    (k_r.st == ses_pkg::LS_TXD && k_r.cnt == 4'h8 && sda_i && k_r.start_s2 == k_r.start_seen
    && !k_r.halt_s2) |=> !k_r.drive && k_r.st == ses_pkg::LS_IDLE) else $error("line held after nack");
  a_read_enters: assert property (@(posedge scl) disable iff (!rst_n) // [R16]
    (k_r.st == ses_pkg::LS_CTRL && k_r.cnt == 4'h8 && k_r.drive && k_r.ctl[0]
    && k_r.start_s2 == k_r.start_seen && !k_r.halt_s2) |=> k_r.st == ses_pkg::LS_TXD)
    else $error("read not started");

endmodule

//--- verification/ses_master_model.sv
// Two-wire bus master model that clocks the serial link.
// Assumes the bench resolves the open-drain data wire with a pull-up.
module ses_master_model (
  output logic      scl,      // Serial clock, stands high outside frames
  output logic      sda_low,  // High pulls the data wire low
  input  wire logic sda       // Resolved data wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Idle bus has both lines high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data falls while the clock is high
  task automatic start();
    sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask
  // Data rises while the clock is high
  task automatic stop();
    #20 sda_low = 1'b1;
    #300 scl = 1'b1;
    #100 sda_low = 1'b0;
    #600;
  endtask
  // Nine clocks; bit 0 of tx is the ninth, acknowledge, bit
  // The low phase is stretched so the device's output hold fits inside it
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #20 sda_low = ~tx[i];  // Data changes with clock low only
      #340 scl = 1'b1;
      #20 rx[i] = sda;       // Sample mid-high
      #20 scl = 1'b0;
    end
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the serial slave front end.
// Assumes straps at 3'b101, high voltage set per scenario, short stall limit.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk, rst_n, prog_busy, scl, m_low, sda, hv;
  logic              sda_o, sda_oe, rd_next, cmd_valid, wr_valid, frame_active, stop_seen, bus_timeout;
  logic [7:0]        wr_data, buf_data, rd_val;
  logic [3:0]        buf_head, buf_idx;
  logic [4:0]        wr_count;
  logic [8:0]        rx;
  ses_pkg::ses_cmd_t cmd;
  int                err_total, cmp_count, n_stop, n_wr, n_rd;
  // Pull-up wire: low if any party pulls
  assign sda = ((sda_oe & ~sda_o) | m_low) ? 1'b0 : 1'b1;
  ses_master_model i_ses_master_model (.scl(scl), .sda_low(m_low), .sda(sda));
  ses_bus_slave #(.STALL_CYCLES(2000)) i_ses_bus_slave (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .chip_sel_bit0(1'b1), .chip_sel_bit1(1'b0),
    .chip_sel_bit2(1'b1), .strap_sel0_hv_pin(hv), .prog_busy(prog_busy), .rd_byte(rd_val),
    .rd_next(rd_next), .cmd(cmd), .cmd_valid(cmd_valid), .wr_data(wr_data), .wr_valid(wr_valid),
    .buf_idx(buf_idx), .buf_data(buf_data), .buf_head(buf_head), .wr_count(wr_count),
    .frame_active(frame_active), .stop_seen(stop_seen), .bus_timeout(bus_timeout));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  // Count one-cycle pulses; read before the edge updates them
  always @(posedge sys_clk) begin
    n_stop += stop_seen;
    n_wr += wr_valid;
    n_rd += rd_next;
  end
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole-run bound against a hang
  initial begin
    #500000 err_total++;
    finish_test();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    prog_busy = 1'b0;
    rd_val = 8'h5A;
    hv = 1'b0;
    buf_idx = 4'h0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    // Matching write, then one data byte
    i_ses_master_model.start();
    i_ses_master_model.xfer({8'hAA, 1'b1}, rx);
    check("ack", rx[0], 8'h00);
    check("cls", cmd.cls, ses_pkg::CLS_MEM);
    check("dir", cmd.rd, 8'h00);
    i_ses_master_model.xfer({8'h3C, 1'b1}, rx);
    check("wr_data", wr_data, 8'h3C);
    check("wr_count", wr_count, 8'h01);
    // Sixteen more bytes: the last one replaces the oldest
    for (int i = 1; i < 17; i++) begin
      i_ses_master_model.xfer({8'(i), 1'b1}, rx);
    end
    check("wr_count full", wr_count, 8'h10);
    check("head", buf_head, 8'h01);
    check("newest", buf_data, 8'h10);
    @(negedge sys_clk) buf_idx = 4'h1;
    #10 check("oldest", buf_data, 8'h01);
    i_ses_master_model.stop();
    check("frame", frame_active, 8'h00);
    // Strap mismatch is refused
    i_ses_master_model.start();
    i_ses_master_model.xfer({8'hA2, 1'b1}, rx);
    check("nack cs", rx[0], 8'h01);
    i_ses_master_model.stop();
    // Protect class answers whatever the straps
    @(negedge sys_clk) hv = 1'b1;
    i_ses_master_model.start();
    i_ses_master_model.xfer({8'h62, 1'b1}, rx);
    check("ack prot", rx[0], 8'h00);
    check("cls prot", cmd.cls, ses_pkg::CLS_PROT);
    check("prot on", cmd.prot_en, 8'h01);
    i_ses_master_model.stop();
    // Programming busy withholds acknowledge
    @(negedge sys_clk) prog_busy = 1'b1;
    hv = 1'b0;
    i_ses_master_model.start();
    i_ses_master_model.xfer({8'h62, 1'b1}, rx);
    check("nack busy", rx[0], 8'h01);
    check("prot off", cmd.prot_en, 8'h00);
    i_ses_master_model.stop();
    @(negedge sys_clk) prog_busy = 1'b0;
    // Read one byte, master ends with not-acknowledge
    i_ses_master_model.start();
    i_ses_master_model.xfer({8'hAB, 1'b1}, rx);
    check("dir rd", cmd.rd, 8'h01);
    i_ses_master_model.xfer({8'hFF, 1'b1}, rx);
    check("rd data", rx[8:1], 8'h5A);
    #300 check("released", sda_oe, 8'h00);
    i_ses_master_model.stop();
    // Clock stalls while the device drives a read bit; the stall must free the line
    i_ses_master_model.start();
    i_ses_master_model.xfer({8'hAB, 1'b1}, rx);
    #12000 check("timeout", bus_timeout, 8'h01);
    check("oe stall", sda_oe, 8'h00);
    i_ses_master_model.stop();
    i_ses_master_model.start();
    check("timeout clr", bus_timeout, 8'h00);
    i_ses_master_model.xfer({8'hAA, 1'b1}, rx);
    check("ack again", rx[0], 8'h00);
    i_ses_master_model.stop();
    check("stops", 8'(n_stop), 8'h07);
    check("writes", 8'(n_wr), 8'h11);
    check("rd_next", 8'(n_rd), 8'h09);
    finish_test();
  end
endmodule
